// >>> hw/ebps_sequencer.sv
// external bus phase sequencer: runs core bus requests as five-phase external cycles
// assumes core requests on mclk; ready pin asynchronous to mclk; avalon-mm slave on mclk
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps

module ebps_sequencer #(
    parameter int NUM_CS = 4,
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    // avalon-mm register slave
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    // core request port
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqWrite,
    input wire logic [$clog2(NUM_CS)-1:0] reqCs,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic [DATA_W-1:0] reqWdata,
    output logic rspValid,
    output logic [DATA_W-1:0] rspRdata,
    // external bus pins
    output logic [ADDR_W-1:0] extAddr,
    output logic [NUM_CS-1:0] extCs_n,
    output logic extRd_n,
    output logic extWr_n,
    input wire logic [DATA_W-1:0] extDataIn,
    output logic [DATA_W-1:0] extDataOut,
    output logic extDataOe,
    input wire logic extReady,
    output logic busRefClk
);

    localparam int CS_W = $clog2(NUM_CS);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0] clkCtrl;
    logic [ebps_pkg::TIMING_W-1:0] timingReg [NUM_CS];
    logic avsAck;
    ebps_pkg::ebps_state_t state;
    ebps_pkg::ebps_state_t next_state;
    logic [5:0] cnt;
    logic [5:0] next_cnt;
    ebps_pkg::ebps_timing_t curT;
    logic curWrite;
    logic [CS_W-1:0] curCs;
    logic [CS_W-1:0] lastCs;
    logic lastCsValid;
    logic rdySync1;
    logic rdySync2;
    logic rdySync3;
    logic [5:0] phCnt;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire avsReq = avsRead | avsWrite;
    wire [7:0] byteAddr = {2'h0, avsAddress, 2'h0};
    wire selCtrl = byteAddr == ebps_pkg::OFF_CLK_CTRL;
    wire selStatus = byteAddr == ebps_pkg::OFF_STATUS;
    wire selTiming = byteAddr >= ebps_pkg::OFF_TIMING_BASE
        && byteAddr < ebps_pkg::OFF_TIMING_BASE + 8'(4 * NUM_CS);
    wire [7:0] timingByte = byteAddr - ebps_pkg::OFF_TIMING_BASE;
    wire [CS_W-1:0] timingIdx = timingByte[CS_W+1:2];
    wire avsDoWrite = avsWrite & avsAck;
    wire [31:0] byteMask = {{8{avsByteenable[3]}}, {8{avsByteenable[2]}},
        {8{avsByteenable[1]}}, {8{avsByteenable[0]}}};
    wire [31:0] timingOld = {16'h0, timingReg[timingIdx]};
    wire [31:0] timingNew = (timingOld & ~byteMask) | (avsWritedata & byteMask);
    wire [31:0] ctrlNew = ({30'h0, clkCtrl} & ~byteMask) | (avsWritedata & byteMask);
    wire [31:0] readMux = selCtrl ? {30'h0, clkCtrl}
        : selStatus ? {24'h0, state, state != ebps_pkg::ST_IDLE}
        : selTiming ? timingOld : 32'h0;

    // one wait cycle per access; read data stand in the acknowledge cycle
    assign avsWaitrequest = avsReq & ~avsAck;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avsAck <= 1'b0;
            avsReaddata <= 32'h0;
            clkCtrl <= ebps_pkg::CLK_CTRL_RESET;
        end else begin
            avsAck <= avsReq & ~avsAck;
            if (avsRead && !avsAck) begin
                avsReaddata <= readMux;
            end
            if (avsDoWrite && selCtrl) begin
                clkCtrl <= ctrlNew[1:0];
            end
        end
    end

    generate
        for (genvar i = 0; i < NUM_CS; i++) begin : g_timing
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    timingReg[i] <= ebps_pkg::TIMING_RESET;
                end else if (avsDoWrite && selTiming && timingIdx == CS_W'(i)) begin
                    timingReg[i] <= timingNew[ebps_pkg::TIMING_W-1:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // reference clock output
    // ------------------------------------------------------------
    wire refClkOn = clkCtrl[ebps_pkg::CLK_SRC_SYS_BIT] & clkCtrl[ebps_pkg::HS_DRV_EN_BIT];
    assign busRefClk = mclk & refClkOn;

    // ------------------------------------------------------------
    // ready synchronisation and qualification
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdySync1 <= 1'b0;
            rdySync2 <= 1'b0;
            rdySync3 <= 1'b0;
        end else begin
            rdySync1 <= extReady;
            rdySync2 <= rdySync1;
            rdySync3 <= rdySync2;
        end
    end

    wire rdyLevel = curT.readyAsync ? rdySync3 : rdySync2;
    wire rdyActive = rdyLevel == curT.readyPolHigh;

    // ------------------------------------------------------------
    // phase sequencing
    // ------------------------------------------------------------
    ebps_pkg::ebps_timing_t reqT;
    assign reqT = ebps_pkg::ebps_timing_t'(timingReg[reqCs]);
    wire csChange = !lastCsValid || lastCs != reqCs;
    wire [5:0] abLen = 6'(reqT.addrSetup2) + 6'(csChange ? reqT.addrExt : 2'h0);
    wire [5:0] accLen = 6'(curT.access) + 6'(curT.readyEn & curT.readyAsync);
    wire phaseLast = cnt == 6'h0;
    wire accEnd = phaseLast && (!curT.readyEn || rdyActive);
    wire start = reqValid && state == ebps_pkg::ST_IDLE;

    assign reqReady = state == ebps_pkg::ST_IDLE;

    always_comb begin
        next_state = state;
        next_cnt = phaseLast ? 6'h0 : cnt - 6'h1;
        unique case (state)
            ebps_pkg::ST_IDLE: begin
                if (reqValid) begin
                    next_state = ebps_pkg::ST_AB;
                    next_cnt = abLen;
                end
            end
            ebps_pkg::ST_AB: begin
                if (phaseLast) begin
                    if (curT.cmdDelay != 2'h0) begin
                        next_state = ebps_pkg::ST_C;
                        next_cnt = 6'(curT.cmdDelay) - 6'h1;
                    end else if (curT.wdSetup) begin
                        next_state = ebps_pkg::ST_D;
                        next_cnt = 6'h0;
                    end else begin
                        next_state = ebps_pkg::ST_E;
                        next_cnt = accLen;
                    end
                end
            end
            ebps_pkg::ST_C: begin
                if (phaseLast) begin
                    next_state = curT.wdSetup ? ebps_pkg::ST_D : ebps_pkg::ST_E;
                    next_cnt = curT.wdSetup ? 6'h0 : accLen;
                end
            end
            ebps_pkg::ST_D: begin
                next_state = ebps_pkg::ST_E;
                next_cnt = accLen;
            end
            ebps_pkg::ST_E: begin
                if (accEnd) begin
                    next_state = curT.hold != 2'h0 ? ebps_pkg::ST_F : ebps_pkg::ST_END;
                    next_cnt = 6'(curT.hold) - 6'h1;
                end
            end
            ebps_pkg::ST_F: begin
                if (phaseLast) begin
                    next_state = ebps_pkg::ST_END;
                end
            end
            ebps_pkg::ST_END: begin
                next_state = ebps_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ebps_pkg::ST_IDLE;
            cnt <= 6'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // ------------------------------------------------------------
    // cycle context and pin drivers
    // ------------------------------------------------------------
    wire inCycle = state != ebps_pkg::ST_IDLE && state != ebps_pkg::ST_END;
    wire cmdPhase = state == ebps_pkg::ST_D || state == ebps_pkg::ST_E;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            curT <= ebps_pkg::ebps_timing_t'(ebps_pkg::TIMING_RESET);
            curWrite <= 1'b0;
            curCs <= '0;
            lastCs <= '0;
            lastCsValid <= 1'b0;
            extAddr <= '0;
            extDataOut <= '0;
            rspValid <= 1'b0;
            rspRdata <= '0;
        end else begin
            rspValid <= 1'b0;
            if (start) begin
                curT <= reqT;
                curWrite <= reqWrite;
                curCs <= reqCs;
                lastCs <= reqCs;
                lastCsValid <= 1'b1;
                extAddr <= reqAddr;
                extDataOut <= reqWdata;
            end
            if (state == ebps_pkg::ST_E && accEnd) begin
                rspValid <= 1'b1;
                rspRdata <= curWrite ? rspRdata : extDataIn;
            end
        end
    end

    generate
        for (genvar i = 0; i < NUM_CS; i++) begin : g_cs
            assign extCs_n[i] = !(inCycle && curCs == CS_W'(i));
        end
    endgenerate

    assign extRd_n = !(cmdPhase && !curWrite);
    assign extWr_n = !(cmdPhase && curWrite);
    assign extDataOe = curWrite && (cmdPhase || state == ebps_pkg::ST_F);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phCnt <= 6'h0;
        end else begin
            phCnt <= next_state != state ? 6'h0 : phCnt + 6'h1;
        end
    end

    chk_start_order: assert property (@(posedge mclk) disable iff (!rst_n)
        start |=> state == ebps_pkg::ST_AB)
        else $error("cycle did not start with address setup");
    chk_ab_next: assert property (@(posedge mclk) disable iff (!rst_n)
        state == ebps_pkg::ST_AB && next_state != state |-> next_state inside
        {ebps_pkg::ST_C, ebps_pkg::ST_D, ebps_pkg::ST_E})
        else $error("address setup left to wrong phase");
    chk_ab_len: assert property (@(posedge mclk) disable iff (!rst_n)
        state == ebps_pkg::ST_AB |-> phCnt < 6'd5)
        else $error("address setup longer than five periods");
    chk_wd_len: assert property (@(posedge mclk) disable iff (!rst_n)
        state == ebps_pkg::ST_D |=> state == ebps_pkg::ST_E)
        else $error("data setup longer than one period");
    chk_hold_len: assert property (@(posedge mclk) disable iff (!rst_n)
        state inside {ebps_pkg::ST_C, ebps_pkg::ST_F} |-> phCnt < 6'd3)
        else $error("command delay or hold longer than three periods");
    chk_access_min: assert property (@(posedge mclk) disable iff (!rst_n)
        state == ebps_pkg::ST_E && next_state != state |-> phCnt >= 6'(curT.access))
        else $error("access phase shorter than programmed");
    chk_ready_wait: assert property (@(posedge mclk) disable iff (!rst_n)
        state == ebps_pkg::ST_E && phaseLast && curT.readyEn && !rdyActive
        |=> state == ebps_pkg::ST_E)
        else $error("inactive ready did not add a waitstate");
    chk_async_ws: assert property (@(posedge mclk) disable iff (!rst_n)
        state == ebps_pkg::ST_E && next_state != state && curT.readyEn && curT.readyAsync
        |-> phCnt >= 6'(curT.access) + 6'd1)
        else $error("async ready without extra waitstate");
    chk_idle_gap: assert property (@(posedge mclk) disable iff (!rst_n)
        state == ebps_pkg::ST_END |-> extCs_n == '1 && extRd_n && extWr_n ##1 state == ebps_pkg::ST_IDLE)
        else $error("outputs active between cycles");
    chk_refclk_gate: assert property (@(negedge mclk) disable iff (!rst_n)
        busRefClk == (clkCtrl[ebps_pkg::CLK_SRC_SYS_BIT] && clkCtrl[ebps_pkg::HS_DRV_EN_BIT]))
        else $error("reference clock output does not follow source and driver enable");

endmodule // ebps_sequencer

// >>> shared/ebps_pkg.sv
// package of the external bus phase sequencer: register map, timing field layout, states
// assumes a 32-bit avalon-mm word-addressed register port
package ebps_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CLK_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_TIMING_BASE = 8'h10;

    // ------------------------------------------------------------
    // clock control fields and reset values
    // ------------------------------------------------------------
    localparam int CLK_SRC_SYS_BIT = 0;
    localparam int HS_DRV_EN_BIT = 1;
    localparam logic [1:0] CLK_CTRL_RESET = 2'h0;

    // ------------------------------------------------------------
    // chip_select_timing_reg layout, lengths in system_clock_period units
    // ------------------------------------------------------------
    typedef struct packed {
        logic readyAsync;     // [15] ready passes an extra sync stage
        logic readyPolHigh;   // [14] ready active level is high
        logic readyEn;        // [13] access phase may be stretched
        logic [1:0] hold;     // [12:11] 0..3
        logic [4:0] access;   // [10:6] value+1 gives 1..32
        logic wdSetup;        // [5] 0..1
        logic [1:0] cmdDelay; // [4:3] 0..3
        logic [1:0] addrExt;  // [2:1] 0..3 extra when window changes
        logic addrSetup2;     // [0] 1 or 2
    } ebps_timing_t;
    localparam int TIMING_W = 16;
    localparam logic [15:0] TIMING_RESET = 16'h07c1;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_AB = 7'h02,
        ST_C = 7'h04,
        ST_D = 7'h08,
        ST_E = 7'h10,
        ST_F = 7'h20,
        ST_END = 7'h40
    } ebps_state_t;

endpackage

// >>> test/ebps_ext_mem.sv
// behavioural memory on the far side of the parallel bus, with a programmable ready delay
// assumes one chip select low at a time and the bus sampled on mclk
`timescale 1ns/100ps
module ebps_ext_mem (
    input wire logic mclk,
    input wire logic [23:0] extAddr,
    input wire logic [3:0] extCs_n,
    input wire logic extRd_n,
    input wire logic extWr_n,
    input wire logic [15:0] extDataOut,
    input wire logic extDataOe,
    input wire logic [3:0] readyWait,
    input wire logic readyActHigh,
    output logic [15:0] extDataIn,
    output logic extReady
);
    logic [15:0] mem [16];
    logic [15:0] lastData = 16'h0;
    logic [3:0] cmdCnt = 4'h0;
    wire cmdOn = (extCs_n != 4'hf) && !(extRd_n && extWr_n);
    wire driveRd = cmdOn && !extRd_n;
    // released data bus shows the inverse of its last value
    assign extDataIn = driveRd ? mem[extAddr[3:0]] : ~lastData;
    // ready active after readyWait command cycles, inactive outside commands
    assign extReady = (cmdOn && cmdCnt >= readyWait) ? readyActHigh : !readyActHigh;
    always @(posedge mclk) begin
        cmdCnt <= !cmdOn ? 4'h0 : (cmdCnt == 4'hf ? cmdCnt : cmdCnt + 4'h1);
        if (driveRd) lastData <= mem[extAddr[3:0]];
        if (cmdOn && !extWr_n && extDataOe) mem[extAddr[3:0]] <= extDataOut;
    end
endmodule // ebps_ext_mem

// >>> test/external_bus_phase_sequencer_test.sv
// self-checking bench of the phase sequencer: registers, phase lengths, ready, reference clock
// assumes the register map of ebps_pkg and the behavioural memory ebps_ext_mem
`timescale 1ns/100ps
module external_bus_phase_sequencer_test;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avsAddress = 4'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata;
    logic avsWaitrequest, reqReady, rspValid, extRd_n, extWr_n, extDataOe, extReady, busRefClk;
    logic reqValid = 1'b0;
    logic reqWrite = 1'b0;
    logic [1:0] reqCs = 2'h0;
    logic [23:0] reqAddr = 24'h0;
    logic [15:0] reqWdata = 16'h0;
    logic [15:0] rspRdata, extDataIn, extDataOut;
    logic [23:0] extAddr;
    logic [3:0] extCs_n;
    logic [3:0] readyWait = 4'hf;
    logic readyActHigh = 1'b1;
    int preC, cmdC, postC, err_total, checks_done;
    int prevCs = -1;
    int cfg [5][6] = '{'{0, 3, 0, 0, 1, 0}, '{1, 3, 3, 1, 32, 3}, '{1, 1, 2, 1, 2, 1}, '{0, 2, 1, 0, 7, 2},
        '{1, 2, 0, 1, 1, 0}};
    logic [2:0] rmode [4] = '{3'b011, 3'b001, 3'b111, 3'b101};
    logic [3:0] rwait [4] = '{4'h8, 4'h5, 4'h0, 4'h3};

    always #12.5 mclk = ~mclk;

    ebps_sequencer i_ebps_sequencer (.mclk(mclk), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(4'hf), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
        .reqCs(reqCs), .reqAddr(reqAddr), .reqWdata(reqWdata), .rspValid(rspValid), .rspRdata(rspRdata),
        .extAddr(extAddr), .extCs_n(extCs_n), .extRd_n(extRd_n), .extWr_n(extWr_n), .extDataIn(extDataIn),
        .extDataOut(extDataOut), .extDataOe(extDataOe), .extReady(extReady), .busRefClk(busRefClk));
    ebps_ext_mem i_ebps_ext_mem (.mclk(mclk), .extAddr(extAddr), .extCs_n(extCs_n), .extRd_n(extRd_n),
        .extWr_n(extWr_n), .extDataOut(extDataOut), .extDataOe(extDataOe), .readyWait(readyWait),
        .readyActHigh(readyActHigh), .extDataIn(extDataIn), .extReady(extReady));

    // ------------------------------------------------------------
    // phase monitor: cycles with chip select low before, during and after the command
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (reqValid && reqReady) begin
            preC <= 0;
            cmdC <= 0;
            postC <= 0;
        end else if (extCs_n != 4'hf) begin
            if (!extRd_n || !extWr_n) cmdC <= cmdC + 1;
            else if (cmdC == 0) preC <= preC + 1;
            else postC <= postC + 1;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        avsAddress <= a;
        avsWrite <= w;
        avsRead <= !w;
        avsWritedata <= d;
        // wait for the slave's answer; only the watchdog ends a hang
        do @(posedge mclk); while (avsWaitrequest !== 1'b0);
        q = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        av(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        av(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    function automatic logic [31:0] tv(input int s2, ext, cmd, wd, acc, hold, input logic [2:0] rdy);
        return {16'h0, rdy, 2'(hold), 5'(acc - 1), 1'(wd), 2'(cmd), 2'(ext), 1'(s2)};
    endfunction

    task automatic run(input logic w, input logic [1:0] cs, input logic [15:0] d, output int len,
        output logic [15:0] q);
        @(posedge mclk);
        reqValid <= 1'b1;
        reqWrite <= w;
        reqCs <= cs;
        reqAddr <= {22'h0, cs};
        reqWdata <= d;
        do @(posedge mclk); while (reqReady !== 1'b1);
        reqValid <= 1'b0;
        len = 0;
        do begin
            @(posedge mclk);
            len++;
        end while (rspValid !== 1'b1);
        q = rspRdata;
        repeat (5) @(posedge mclk);
        chk({extCs_n, extRd_n, extWr_n}, 6'h3f);
    endtask

    task automatic plain(input int i, input logic w);
        int len, ab;
        logic [15:0] q;
        ab = (cfg[i][0] ? 2 : 1) + ((prevCs != i % 4) ? cfg[i][1] : 0);
        wr(ebps_pkg::OFF_TIMING_BASE[5:2] + 4'(i % 4), tv(cfg[i][0], cfg[i][1], cfg[i][2], cfg[i][3],
            cfg[i][4], cfg[i][5], 3'h0));
        run(w, 2'(i), 16'h5a00 + 16'(i % 4), len, q);
        chk(len, ab + cfg[i][2] + cfg[i][3] + cfg[i][4] + 1);
        chk(preC, ab + cfg[i][2]);
        chk(cmdC, cfg[i][3] + cfg[i][4]);
        chk(postC, cfg[i][5]);
        if (!w) chk(q, 16'h5a00 + 16'(i % 4));
        prevCs = i % 4;
    endtask

    task automatic report_and_stop;
        $display("checks %0d, errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        int len;
        logic [15:0] q;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        rd(4'h4, 32'h07c1);
        rd(4'h0, 32'h0);
        rd(4'hf, 32'h0);
        wr(4'h1, 32'hffffffff);
        rd(4'h1, 32'h2);
        wr(4'h7, 32'hffffffff);
        rd(4'h7, 32'hffff);
        for (int v = 0; v < 4; v++) begin
            wr(4'h0, 32'(v));
            @(posedge mclk);
            #2;
            chk(busRefClk, v == 3);
            @(negedge mclk);
            #2;
            chk(busRefClk, 1'b0);
        end
        for (int i = 0; i < 5; i++) begin
            plain(i, 1'b1);
            plain(i, 1'b0);
        end
        for (int k = 0; k < 4; k++) begin
            readyWait <= rwait[k];
            readyActHigh <= rmode[k][1];
            wr(ebps_pkg::OFF_TIMING_BASE[5:2] + 4'h3, tv(1, 0, 0, 0, 1, 0, rmode[k]));
            run(1'b0, 2'h3, 16'h0, len, q);
            chk(q, 16'h5a03);
            // ready seen through two flops, three in async mode, then sampled at the end of access
            chk(cmdC, rwait[k] + 3 + rmode[k][2]);
            chk(cmdC <= rwait[k] + 6, 1'b1);
        end
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        report_and_stop();
    end
endmodule // external_bus_phase_sequencer_test
